// [design/stl_motion_supervisor.sv]
// travel limit, target speed, stop and standstill band supervisor with axi4-lite regs
// Operation
// - positive limit checked only moving positive, negative limit only moving negative
// - compare commanded position, not encoder position; exceed starts a stop
// - check only when enabled and a non-homing motion is running
// - checking off after reset and at every program start
// - negative limit resets to -2147481647 counts, readable and writable
// - positive limit resets to +2147481647 counts, readable and writable
// - limit stop decelerates with the maximum acceleration value
// - error code 130 for positive limit, 131 for negative limit
// - disable command turns off both limits at once
// - enable command turns on both limits, keeping stored values
// - speed write clamps negative to zero and above max to max
// - target speed resets to a quarter of max speed
// - new target speed goes to profile generator at once
// - speed resolves down to 0.00015 rev per second
// - stop command uses the programmed deceleration profile
// - stop does not latch any motion inhibit
// - zero band disables standstill correction, nonzero enables it
// - band saturates at 32767 counts
// - band resets to 0.005 revolution at power on and program start
// - timer counts up one step each millisecond
// - timer wraps from +2147481647 ms to -2147481647 ms
// - timer write loads the value, read returns the count
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "stl_params.svh"
module stl_motion_supervisor
   import stl_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] cmdPosition,
   input wire logic motionActive,
   input wire logic moveDirNeg,
   input wire logic homingRun,
   output logic stopRequest,
   output logic useMaxAccelDecel,
   output logic [31:0] targetSpeed,
   output logic [31:0] standstillBand,
   output logic positionMaintainEn,
   output logic [7:0] errorCode
);
   logic [7:0] awAddrQ;
   logic awHeldQ;
   logic [31:0] wDataQ;
   logic [3:0] wStrbQ;
   logic wHeldQ;
   logic wrFire;
   logic [31:0] wrMerged;
   logic [31:0] wrOld;
   logic [31:0] rdMux;
   logic rdHit;
   logic wrHit;
   logic checkOnQ;
   logic [31:0] negLimitQ;
   logic [31:0] posLimitQ;
   logic [31:0] maxSpeedQ;
   logic [31:0] speedQ;
   logic [31:0] bandQ;
   logic [31:0] cntPerRevQ;
   logic [31:0] timerCount;
   stl_stop_t stopStateQ;
   logic [7:0] errQ;
   logic posTrip;
   logic negTrip;
   logic checkActive;
   logic ctrlWr;
   logic progStart;
   logic negLimWr;
   logic posLimWr;
   logic speedWr;
   logic maxSpeedWr;
   logic bandWr;
   logic cntRevWr;
   logic timerLoad;
   logic [31:0] bandInit;
   logic [31:0] clampSpeed;
   logic [31:0] clampBand;

   // write channel: address and data accepted in either order
   assign s_axi_awready = !awHeldQ && !s_axi_bvalid;
   assign s_axi_wready = !wHeldQ && !s_axi_bvalid;
   assign wrFire = awHeldQ && wHeldQ && !s_axi_bvalid;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         awHeldQ <= 1'b0;
         awAddrQ <= 8'h00;
         wHeldQ <= 1'b0;
         wDataQ <= 32'h0000_0000;
         wStrbQ <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeldQ <= 1'b1;
            awAddrQ <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeldQ <= 1'b1;
            wDataQ <= s_axi_wdata;
            wStrbQ <= s_axi_wstrb;
         end
         if (wrFire) begin
            awHeldQ <= 1'b0;
            wHeldQ <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrHit ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      wrHit = 1'b1;
      unique case (awAddrQ)
         `STL_OFS_CTRL: wrOld = 32'h0000_0000;
         `STL_OFS_NEG_LIM: wrOld = negLimitQ;
         `STL_OFS_POS_LIM: wrOld = posLimitQ;
         `STL_OFS_SPEED: wrOld = speedQ;
         `STL_OFS_MAX_SPEED: wrOld = maxSpeedQ;
         `STL_OFS_BAND: wrOld = bandQ;
         `STL_OFS_TIMER: wrOld = timerCount;
         `STL_OFS_CNT_REV: wrOld = cntPerRevQ;
         default: begin
            wrOld = 32'h0000_0000;
            wrHit = 1'b0;
         end
      endcase
   end

   // byte-lane merge of write data onto the old value
   for (genvar b = 0; b < 4; b++) begin : gLane
      assign wrMerged[8*b +: 8] = wStrbQ[b] ? wDataQ[8*b +: 8] : wrOld[8*b +: 8];
   end

   // write strobes as plain nets so each one follows wrFire and the held address
   assign ctrlWr = wrFire && (awAddrQ == `STL_OFS_CTRL);
   assign negLimWr = wrFire && (awAddrQ == `STL_OFS_NEG_LIM);
   assign posLimWr = wrFire && (awAddrQ == `STL_OFS_POS_LIM);
   assign speedWr = wrFire && (awAddrQ == `STL_OFS_SPEED);
   assign maxSpeedWr = wrFire && (awAddrQ == `STL_OFS_MAX_SPEED);
   assign bandWr = wrFire && (awAddrQ == `STL_OFS_BAND);
   assign cntRevWr = wrFire && (awAddrQ == `STL_OFS_CNT_REV);
   assign timerLoad = wrFire && (awAddrQ == `STL_OFS_TIMER);
   assign progStart = ctrlWr && wrMerged[`STL_CTRL_START_BIT];

   // signed clamps for speed and band
   always_comb begin
      if ($signed(wrMerged) < 0) begin
         clampSpeed = 32'h0000_0000;
      end else if ($signed(wrMerged) > $signed(maxSpeedQ)) begin
         clampSpeed = maxSpeedQ;
      end else begin
         clampSpeed = wrMerged;
      end
      if ($signed(wrMerged) < 0) begin
         clampBand = 32'h0000_0000;
      end else if ($signed(wrMerged) > $signed(`STL_BAND_MAX)) begin
         clampBand = `STL_BAND_MAX;
      end else begin
         clampBand = wrMerged;
      end
   end

   // 0.005 rev in counts, saturated
   always_comb begin
      bandInit = cntPerRevQ / 32'(`STL_BAND_RST_DIV);
      if (bandInit > `STL_BAND_MAX) begin
         bandInit = `STL_BAND_MAX;
      end
   end

   // off wins over on when both bits are written together
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         checkOnQ <= 1'b0;
      end else if (progStart) begin
         checkOnQ <= 1'b0;
      end else if (ctrlWr && wrMerged[`STL_CTRL_OFF_BIT]) begin
         checkOnQ <= 1'b0;
      end else if (ctrlWr && wrMerged[`STL_CTRL_ON_BIT]) begin
         checkOnQ <= 1'b1;
      end
   end

   // limits stay put across program start; only checking is turned off there
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         negLimitQ <= `STL_LIMIT_NEG_RST;
         posLimitQ <= `STL_LIMIT_POS_RST;
      end else begin
         if (negLimWr) begin
            negLimitQ <= wrMerged;
         end
         if (posLimWr) begin
            posLimitQ <= wrMerged;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         maxSpeedQ <= `STL_MAX_SPEED_RST;
         cntPerRevQ <= `STL_CNT_REV_RST;
      end else begin
         if (maxSpeedWr) begin
            maxSpeedQ <= wrMerged;
         end
         if (cntRevWr) begin
            cntPerRevQ <= wrMerged;
         end
      end
   end

   // lowering max speed also pulls an over-range target down
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         speedQ <= `STL_MAX_SPEED_RST >> 2;
      end else if (speedWr) begin
         speedQ <= clampSpeed;
      end else if (maxSpeedWr && !wrMerged[31] && speedQ > wrMerged) begin
         speedQ <= wrMerged;
      end
   end
   assign targetSpeed = speedQ;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bandQ <= `STL_CNT_REV_RST / 32'(`STL_BAND_RST_DIV);
      end else if (progStart) begin
         bandQ <= bandInit;
      end else if (bandWr) begin
         bandQ <= clampBand;
      end
   end
   assign standstillBand = bandQ;
   assign positionMaintainEn = (bandQ != 32'h0000_0000);

   // limit evaluation on commanded position
   assign checkActive = checkOnQ && motionActive && !homingRun;
   assign posTrip = checkActive && !moveDirNeg
      && ($signed(cmdPosition) > $signed(posLimitQ));
   assign negTrip = checkActive && moveDirNeg
      && ($signed(cmdPosition) < $signed(negLimitQ));

   // a stop only applies to a running move, so nothing carries over to the next one
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         stopStateQ <= STL_RUN;
      end else if (posTrip || negTrip) begin
         stopStateQ <= STL_LIM_STOP;
      end else if (ctrlWr && wrMerged[`STL_CTRL_STOP_BIT] && motionActive
         && stopStateQ == STL_RUN) begin
         stopStateQ <= STL_CMD_STOP;
      end else if (!motionActive) begin
         stopStateQ <= STL_RUN;
      end
   end

   // a trip in the same cycle as a clear keeps the code
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         errQ <= 8'h00;
      end else if (posTrip) begin
         errQ <= `STL_ERR_POS;
      end else if (negTrip) begin
         errQ <= `STL_ERR_NEG;
      end else if (ctrlWr && wrMerged[`STL_CTRL_ERRCLR_BIT]) begin
         errQ <= 8'h00;
      end
   end
   assign errorCode = errQ;

   assign stopRequest = (stopStateQ != STL_RUN) && motionActive;
   assign useMaxAccelDecel = (stopStateQ == STL_LIM_STOP);

   stl_ms_timer uTimer (
      .mclk(mclk),
      .rst_b(rst_b),
      .load(timerLoad),
      .loadValue(wrMerged),
      .count(timerCount)
   );

   // read channel, one-cycle latency
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      rdHit = 1'b1;
      unique case (s_axi_araddr)
         `STL_OFS_CTRL: rdMux = {31'h0000_0000, checkOnQ};
         `STL_OFS_STATUS: rdMux = {28'h000_0000, positionMaintainEn, useMaxAccelDecel,
            stopRequest, checkOnQ};
         `STL_OFS_NEG_LIM: rdMux = negLimitQ;
         `STL_OFS_POS_LIM: rdMux = posLimitQ;
         `STL_OFS_SPEED: rdMux = speedQ;
         `STL_OFS_MAX_SPEED: rdMux = maxSpeedQ;
         `STL_OFS_BAND: rdMux = bandQ;
         `STL_OFS_TIMER: rdMux = timerCount;
         `STL_OFS_CNT_REV: rdMux = cntPerRevQ;
         `STL_OFS_ERR: rdMux = {24'h00_0000, errQ};
         default: begin
            rdMux = 32'h0000_0000;
            rdHit = 1'b0;
         end
      endcase
   end

   // rdata holds after the handshake until the next read is taken
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdMux;
         s_axi_rresp <= rdHit ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [design/stl_ms_timer.sv]
// free-running millisecond timer with wrap and load
`timescale 1ns/1ps
`default_nettype none
`include "stl_params.svh"
module stl_ms_timer
   import stl_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic load,
   input wire logic [31:0] loadValue,
   output logic [31:0] count
);
   localparam logic [15:0] TICK_LAST = 16'(`STL_TICK_CYCLES - 1);
   logic [15:0] divQ;
   logic tick;

   assign tick = (divQ == TICK_LAST);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         divQ <= 16'h0000;
      end else if (load || tick) begin
         divQ <= 16'h0000;
      end else begin
         divQ <= divQ + 16'h0001;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count <= 32'h0000_0000;
      end else if (load) begin
         count <= loadValue;
      end else if (tick) begin
         if (count == `STL_TIMER_MAX) begin
            count <= `STL_TIMER_MIN;
         end else begin
            count <= count + 32'h0000_0001;
         end
      end
   end
endmodule
`default_nettype wire

// [design/stl_params.svh]
// constants for the travel limit, speed and timer block
`ifndef STL_PARAMS_SVH
`define STL_PARAMS_SVH
`define STL_CLK_HZ 40000000
`define STL_TICK_PERIOD_US 1000
`define STL_TICK_CYCLES ((`STL_CLK_HZ / 1000000) * `STL_TICK_PERIOD_US)
`define STL_LIMIT_NEG_RST 32'h8000_07D1
`define STL_LIMIT_POS_RST 32'h7FFF_F82F
`define STL_TIMER_MAX 32'h7FFF_F82F
`define STL_TIMER_MIN 32'h8000_07D1
`define STL_ERR_POS 8'h82
`define STL_ERR_NEG 8'h83
`define STL_BAND_MAX 32'h0000_7FFF
`define STL_BAND_RST_DIV 200
`define STL_MAX_SPEED_RST 32'h0001_0000
`define STL_SPEED_MIN_RES 32'h0000_0001
`define STL_OFS_CTRL 8'h00
`define STL_OFS_STATUS 8'h04
`define STL_OFS_NEG_LIM 8'h08
`define STL_OFS_POS_LIM 8'h0C
`define STL_OFS_SPEED 8'h10
`define STL_OFS_MAX_SPEED 8'h14
`define STL_OFS_BAND 8'h18
`define STL_OFS_TIMER 8'h1C
`define STL_OFS_CNT_REV 8'h20
`define STL_OFS_ERR 8'h24
`define STL_CTRL_ON_BIT 0
`define STL_CTRL_OFF_BIT 1
`define STL_CTRL_STOP_BIT 2
`define STL_CTRL_START_BIT 3
`define STL_CTRL_ERRCLR_BIT 4
`define STL_CNT_REV_RST 32'h0000_0FA0
`endif

// [design/stl_pkg.sv]
// types for the travel limit, speed and timer block
package stl_pkg;
   typedef enum logic [1:0] {STL_RUN, STL_LIM_STOP, STL_CMD_STOP} stl_stop_t;
   typedef enum logic [1:0] {STL_DEC_NONE, STL_DEC_PROG, STL_DEC_MAX} stl_decel_t;
endpackage

// [dv/stl_monitor.sv]
// port assertions for the motion supervisor
`timescale 1ns/1ps
`default_nettype none
module stl_monitor (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic motionActive,
   input wire logic moveDirNeg,
   input wire logic homingRun,
   input wire logic stopRequest,
   input wire logic useMaxAccelDecel,
   input wire logic [31:0] targetSpeed,
   input wire logic [31:0] standstillBand,
   input wire logic positionMaintainEn,
   input wire logic [7:0] errorCode
);
   logic runPos_q;
   logic runNeg_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // checked motion in each direction during the previous cycle
   always_ff @(posedge mclk) begin
      runPos_q <= motionActive && !homingRun && !moveDirNeg;
      runNeg_q <= motionActive && !homingRun && moveDirNeg;
   end
   property p_rst;
      $rose(rst_b) |-> targetSpeed == 32'h0000_4000 && standstillBand == 32'h0000_0014;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset value");
   property p_pos; $changed(errorCode) && errorCode == 8'h82 |-> runPos_q; endproperty
   a_pos: assert property (p_pos) else $error("bad positive trip");
   property p_neg; $changed(errorCode) && errorCode == 8'h83 |-> runNeg_q; endproperty
   a_neg: assert property (p_neg) else $error("bad negative trip");
   property p_home; motionActive && homingRun && errorCode == 8'h00 |=> errorCode == 8'h00; endproperty
   a_home: assert property (p_home) else $error("homing tripped");
   property p_idle;
      !motionActive ##1 motionActive |-> !stopRequest && !useMaxAccelDecel;
   endproperty
   a_idle: assert property (p_idle) else $error("stop carried into new move");
   property p_dec; $changed(errorCode) && errorCode != 8'h00 |-> useMaxAccelDecel; endproperty
   a_dec: assert property (p_dec) else $error("limit stop not at max rate");
   property p_band; standstillBand <= 32'h0000_7FFF; endproperty
   a_band: assert property (p_band) else $error("band too large");
   property p_maint; positionMaintainEn == (standstillBand != 32'h0000_0000); endproperty
   a_maint: assert property (p_maint) else $error("maintain flag wrong");
   property p_spd; targetSpeed <= 32'h0001_0000; endproperty
   a_spd: assert property (p_spd) else $error("speed above max");
   c_pos: cover property (errorCode == 8'h82);
   c_neg: cover property (errorCode == 8'h83);
   c_stop: cover property (stopRequest && !useMaxAccelDecel);
endmodule
bind stl_motion_supervisor stl_monitor i_stl_monitor (.*);
`default_nettype wire

// [dv/stl_motion_model.sv]
// profile generator stand-in on the drive side
`timescale 1ns/1ps
`default_nettype none
module stl_motion_model (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic dirNeg,
   input wire logic home,
   input wire logic halt,
   input wire logic [31:0] startPos,
   input wire logic stopRequest,
   input wire logic useMaxAccelDecel,
   output logic [31:0] cmdPosition,
   output logic motionActive,
   output logic moveDirNeg,
   output logic homingRun
);
   logic [3:0] ramp_q;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cmdPosition <= 32'h0000_0000;
         motionActive <= 1'b0;
         moveDirNeg <= 1'b0;
         homingRun <= 1'b0;
         ramp_q <= 4'h0;
      end else if (!motionActive) begin
         if (start) begin
            cmdPosition <= startPos;
            motionActive <= 1'b1;
            moveDirNeg <= dirNeg;
            homingRun <= home;
            ramp_q <= 4'h0;
         end
      end else if (stopRequest || halt) begin
         // a limit stop ramps down faster than a programmed one
         ramp_q <= ramp_q + 4'h1;
         if (ramp_q >= (useMaxAccelDecel ? 4'h2 : 4'h6))
            motionActive <= 1'b0;
      end else begin
         cmdPosition <= moveDirNeg ? cmdPosition - 32'h0000_0001 : cmdPosition + 32'h0000_0001;
      end
   end
endmodule
`default_nettype wire

// [dv/tb_stl_motion_supervisor.sv]
// self-checking bench for the motion supervisor
`timescale 1ns/1ps
`default_nettype none
`include "stl_params.svh"
module tb_stl_motion_supervisor;
   logic mclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic motionActive, moveDirNeg, homingRun, stopRequest, useMaxAccelDecel, positionMaintainEn;
   logic rst_b = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, start = 1'b0, halt = 1'b0;
   logic dirNeg = 1'b0, home = 1'b0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, errorCode;
   logic [31:0] s_axi_wdata = 32'h0000_0000, startPos = 32'h0000_0000, v, e;
   logic [31:0] s_axi_rdata, cmdPosition, targetSpeed, standstillBand;
   int nFail, checks;
   stl_motion_supervisor i_stl_motion_supervisor (.*);
   stl_motion_model i_stl_motion_model (.*);
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic endOfTest;
      $display("checks %0d mismatches %0d", checks, nFail);
      if (nFail == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         nFail++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tmo;
      chk(32'h0000_0000, 32'h0000_0001);
      endOfTest();
   endtask
   function automatic logic [31:0] clampTo(input logic [31:0] x, input logic [31:0] m);
      if (x[31]) return 32'h0000_0000;
      return (x > m) ? m : x;
   endfunction
   // one write (w high) or one read; d is write data or expected read data
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = 2'b00);
      int k;
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      for (k = 0; k < 50; k++) begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_bvalid || s_axi_rvalid) break;
      end
      if (k == 50) tmo();
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      chk(w ? s_axi_bresp : s_axi_rresp, r);
      if (!w) chk(s_axi_rdata, d);
      @(posedge mclk);
   endtask
   task automatic waitIdle;
      int k;
      for (k = 0; k < 200 && motionActive; k++) @(posedge mclk);
      if (k == 200) tmo();
      halt <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic go(input logic [31:0] p, input logic ng, input logic hm);
      startPos <= p;
      dirNeg <= ng;
      home <= hm;
      start <= 1'b1;
      @(posedge mclk);
      start <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic move(input logic [31:0] p, input logic ng, input logic hm, input logic [7:0] x);
      go(p, ng, hm);
      repeat (30) @(posedge mclk);
      halt <= 1'b1;
      @(posedge mclk);
      waitIdle();
      chk(errorCode, x);
   endtask
   initial begin
      static logic [31:0] sc[4] = '{32'hFFFF_FFFF, 32'h0001_0001, 32'h0001_0000, 32'h0000_0001};
      static logic [31:0] bc[4] = '{32'h0000_0000, 32'h0000_9C40, 32'hFFFF_FFF0, 32'h0000_7FFF};
      v = $urandom(32'h1d9c_efc6);
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      bus(1'b0, `STL_OFS_NEG_LIM, 32'h8000_07D1);
      bus(1'b0, `STL_OFS_POS_LIM, 32'h7FFF_F82F);
      bus(1'b0, `STL_OFS_SPEED, 32'h0000_4000);
      bus(1'b0, `STL_OFS_BAND, 32'h0000_0014);
      bus(1'b0, `STL_OFS_CTRL, 32'h0000_0000);
      $display("reset test done");
      for (int i = 0; i < 12; i++) begin
         v = (i < 4) ? sc[i] : $urandom & (i[0] ? 32'hFFFF_FFFF : 32'h0001_FFFF);
         e = clampTo(v, 32'h0001_0000);
         bus(1'b1, `STL_OFS_SPEED, v);
         chk(targetSpeed, e);
         bus(1'b0, `STL_OFS_SPEED, e);
      end
      for (int i = 0; i < 8; i++) begin
         v = (i < 4) ? bc[i] : $urandom & 32'h8000_FFFF;
         e = clampTo(v, 32'h0000_7FFF);
         bus(1'b1, `STL_OFS_BAND, v);
         chk(standstillBand, e);
         chk(positionMaintainEn, e != 32'h0000_0000);
      end
      $display("speed and band test done");
      bus(1'b1, `STL_OFS_POS_LIM, 32'h0000_0064);
      bus(1'b1, `STL_OFS_NEG_LIM, 32'hFFFF_FF9C);
      move(32'h0000_005A, 1'b0, 1'b0, 8'h00);
      bus(1'b1, `STL_OFS_CTRL, 32'h0000_0001);
      bus(1'b0, `STL_OFS_CTRL, 32'h0000_0001);
      bus(1'b0, `STL_OFS_POS_LIM, 32'h0000_0064);
      move(32'h0000_0096, 1'b1, 1'b0, 8'h00);
      move(32'hFFFF_FF6A, 1'b0, 1'b0, 8'h00);
      move(32'h0000_005A, 1'b0, 1'b1, 8'h00);
      move(32'h0000_005A, 1'b0, 1'b0, 8'h82);
      bus(1'b1, `STL_OFS_CTRL, 32'h0000_0010);
      move(32'hFFFF_FFA6, 1'b1, 1'b0, 8'h83);
      bus(1'b1, `STL_OFS_CTRL, 32'h0000_0012);
      move(32'h0000_005A, 1'b0, 1'b0, 8'h00);
      move(32'hFFFF_FFA6, 1'b1, 1'b0, 8'h00);
      bus(1'b1, `STL_OFS_CTRL, 32'h0000_0001);
      bus(1'b1, `STL_OFS_BAND, 32'h0000_0005);
      bus(1'b1, `STL_OFS_CTRL, 32'h0000_0008);
      bus(1'b0, `STL_OFS_CTRL, 32'h0000_0000);
      chk(standstillBand, 32'h0000_0014);
      $display("limit test done");
      go(32'h0000_0000, 1'b0, 1'b0);
      bus(1'b1, `STL_OFS_CTRL, 32'h0000_0004);
      chk(stopRequest, 1'b1);
      chk(useMaxAccelDecel, 1'b0);
      waitIdle();
      bus(1'b1, `STL_OFS_CTRL, 32'h0000_0004);
      go(32'h0000_0000, 1'b0, 1'b0);
      chk(motionActive, 1'b1);
      chk(stopRequest, 1'b0);
      halt <= 1'b1;
      waitIdle();
      $display("stop test done");
      bus(1'b1, 8'h30, 32'h0000_0001, 2'b10);
      bus(1'b1, `STL_OFS_STATUS, 32'h0000_0001, 2'b10);
      bus(1'b0, 8'h30, 32'h0000_0000, 2'b10);
      $display("bus refusal test done");
      bus(1'b1, `STL_OFS_TIMER, 32'h7FFF_F82F);
      bus(1'b0, `STL_OFS_TIMER, 32'h7FFF_F82F);
      repeat (40010) @(posedge mclk);
      bus(1'b0, `STL_OFS_TIMER, 32'h8000_07D1);
      $display("timer test done");
      endOfTest();
   end
endmodule
`default_nettype wire
